//--- rtl/epb_consts.vh
`ifndef EPB_CONSTS_VH
`define EPB_CONSTS_VH

// ==========================================================
// Register window
// ==========================================================
`define EPB_WIN_BYTES 16
`define EPB_IDX_BSR 14
`define EPB_IDX_BSR_HI 15
`define EPB_IDX_CFG 16
`define EPB_BANK_BYTES 14
`define EPB_BANK_TOTAL 56
`define EPB_BSR_HI_VAL 8'h33
`define EPB_NOBANK_VAL 8'h33
`define EPB_BANK_RST 3'h0
`define EPB_CFG_WIDE_RST 1'b1
`define EPB_TCR_HI_IDX 1
`define EPB_CRC_SUPPRESS_OPTION_BIT 0
`define EPB_MT_BASE 42
`define EPB_HTRANS_NONSEQ 2'b10

// ==========================================================
// Packet layout
// ==========================================================
`define EPB_STAT_OFS 11'h000
`define EPB_CNT_OFS 11'h002
`define EPB_DATA_OFS 11'h004
`define EPB_OVERHEAD 6
`define EPB_MAX_DATA 1531
`define EPB_MAX_COUNT 1536
`define EPB_MAX_CABLE 1518
`define EPB_MIN_CABLE 64
`define EPB_DA_LEN 6
`define EPB_RX_CTRL_FIXED 8'h40
`define EPB_CTRL_ODD_BIT 5
`define EPB_CTRL_CRC_BIT 4

// ==========================================================
// Receive status word
// ==========================================================
`define EPB_ST_ALIGN 15
`define EPB_ST_BCAST 14
`define EPB_ST_CRCERR 13
`define EPB_ST_ODD 12
`define EPB_ST_LONG 11
`define EPB_ST_SHORT 10
`define EPB_ST_HASH_LSB 1
`define EPB_ST_MCAST 0

// ==========================================================
// Destination address CRC
// ==========================================================
`define EPB_CRC_POLY 32'hedb88320
`define EPB_CRC_INIT 32'hffffffff
`define EPB_HASH_MSB 31
`define EPB_HASH_LSB 26

`endif

//--- rtl/epb_tx_frame.v
`timescale 1ns/1ps
`include "epb_consts.vh"

module epb_tx_frame (
  input wire clk,
  input wire rst_n,
  input wire desc_valid,
  input wire [15:0] byte_count,
  input wire [7:0] control,
  input wire crc_suppress,
  output reg send_valid_q,
  output reg [10:0] send_len_q,
  output reg append_crc_q
);

  localparam [15:0] OVERHEAD = `EPB_OVERHEAD;
  localparam [15:0] MAX_COUNT = `EPB_MAX_COUNT;

  wire [15:0] even_count;
  wire [15:0] clamp_count;
  wire odd_byte;
  wire [15:0] data_len;

  assign even_count = {byte_count[15:1], 1'b0};
  assign clamp_count = (even_count > MAX_COUNT) ? MAX_COUNT : even_count;
  assign odd_byte = control[`EPB_CTRL_ODD_BIT];
  // Status, count and final word leave the data bytes; odd adds one back
  assign data_len = ((clamp_count < OVERHEAD) ? 16'h0000 :
    (clamp_count - OVERHEAD)) + {15'h0000, odd_byte};

  // ==========================================================
  // Descriptor latch
  // ==========================================================
  // Frame bytes go out untouched: no source address or type rewrite.
  always @(posedge clk) begin
    if (!rst_n) begin
      send_valid_q <= 1'b0;
      send_len_q <= 11'h000;
      append_crc_q <= 1'b1;
    end else begin
      send_valid_q <= desc_valid;
      if (desc_valid) begin
        send_len_q <= data_len[10:0];
        append_crc_q <= !crc_suppress | control[`EPB_CTRL_CRC_BIT];
      end
    end
  end

endmodule // epb_tx_frame

//--- rtl/epb_top.v
`timescale 1ns/1ps
`include "epb_consts.vh"

module epb_top (
  input wire MCLK,
  input wire RST_N,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire HREADY,
  input wire [31:0] HWDATA,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire RX_VALID,
  input wire [7:0] RX_DATA,
  input wire RX_LAST,
  input wire RX_ALIGN_ERR,
  input wire RX_CRC_ERR,
  output reg RX_READY,
  output reg PKT_WE,
  output reg [10:0] PKT_ADDR,
  output reg [15:0] PKT_WDATA,
  output reg RX_DONE,
  output reg RX_HASH_HIT,
  input wire TX_DESC_VALID,
  input wire [15:0] TX_BYTE_COUNT,
  input wire [7:0] TX_CONTROL,
  output wire TX_SEND_VALID,
  output wire [10:0] TX_SEND_LEN,
  output wire TX_APPEND_CRC
);

  localparam [1:0] S_RUN = 2'b00;
  localparam [1:0] S_FINAL = 2'b01;
  localparam [1:0] S_COUNT = 2'b10;
  localparam [1:0] S_STATUS = 2'b11;
  localparam [11:0] MAX_DATA = `EPB_MAX_DATA;
  localparam [11:0] MAX_CABLE = `EPB_MAX_CABLE;
  localparam [11:0] MIN_CABLE = `EPB_MIN_CABLE;
  localparam [11:0] DA_LEN = `EPB_DA_LEN;
  localparam [10:0] OVERHEAD = `EPB_OVERHEAD;
  localparam [4:0] IDX_BSR = `EPB_IDX_BSR;
  localparam [4:0] IDX_CFG = `EPB_IDX_CFG;
  localparam [4:0] BANK_BYTES = `EPB_BANK_BYTES;
  localparam [5:0] MT_BASE = `EPB_MT_BASE;

  // ==========================================================
  // Destination address CRC, LSB first
  // ==========================================================
  function [31:0] crc_byte;
    input [31:0] crc_in;
    input [7:0] b;
    integer j;
    reg [31:0] c;
    begin
      c = crc_in;
      for (j = 0; j < 8; j = j + 1) begin
        if (c[0] ^ b[j])
          c = (c >> 1) ^ `EPB_CRC_POLY;
        else
          c = c >> 1;
      end
      // No final inversion: only the top six bits are used
      crc_byte = c;
    end
  endfunction

  // ==========================================================
  // Register window state
  // ==========================================================
  reg [7:0] mem_q [0:`EPB_BANK_TOTAL-1];
  reg [2:0] bank_q;
  reg wide_q;
  reg wr_pend_q;
  reg [4:0] wr_idx_q;
  integer k;

  wire [5:0] bank_base;
  wire [127:0] win_flat;
  wire addr_phase;
  wire [4:0] a_idx;
  wire a_mapped;
  reg [15:0] rd_val;
  wire [5:0] wr_pos;

  // Bank number times fourteen, kept within six bits
  assign bank_base = {bank_q[1:0], 4'h0} - {3'h0, bank_q[1:0], 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < `EPB_WIN_BYTES; gi = gi + 1) begin : g_win
      if (gi == `EPB_IDX_BSR) begin : g_bsr
        assign win_flat[gi*8 +: 8] = {5'h00, bank_q};
      end else if (gi == `EPB_IDX_BSR_HI) begin : g_bsrhi
        assign win_flat[gi*8 +: 8] = `EPB_BSR_HI_VAL;
      end else begin : g_bank
        // Nonexistent bank answers a fixed pattern on bytes 0 to 13; byte 14 still reads the bank number
        assign win_flat[gi*8 +: 8] = bank_q[2] ? `EPB_NOBANK_VAL :
          mem_q[bank_base + gi];
      end
    end
  endgenerate

  assign addr_phase = HSEL & HREADY & (HTRANS == `EPB_HTRANS_NONSEQ);
  assign a_idx = HADDR[6:2];
  assign a_mapped = (HADDR[31:7] == 25'h0000000) && (a_idx <= IDX_CFG);

  // Even index in wide mode reads a word, else one byte
  always @* begin
    rd_val = 16'h0000;
    if (a_idx < IDX_CFG) begin
      if (wide_q && !a_idx[0])
        rd_val = {win_flat[{a_idx[3:0], 3'b000} + 8 +: 8],
                  win_flat[{a_idx[3:0], 3'b000} +: 8]};
      else
        rd_val = {8'h00, win_flat[{a_idx[3:0], 3'b000} +: 8]};
    end else if (a_idx == IDX_CFG) begin
      rd_val = {15'h0000, wide_q};
    end
  end

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  // ==========================================================
  always @(posedge MCLK) begin
    if (!RST_N) begin
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_idx_q <= 5'h00;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      wr_pend_q <= addr_phase & HWRITE & a_mapped;
      if (addr_phase)
        wr_idx_q <= a_idx;
      // Unmapped reads return zero rather than an error response
      if (addr_phase && !HWRITE)
        HRDATA <= a_mapped ? {16'h0000, rd_val} : 32'h00000000;
    end
  end

  assign wr_pos = bank_base + {1'b0, wr_idx_q};

  always @(posedge MCLK) begin
    if (!RST_N) begin
      for (k = 0; k < `EPB_BANK_TOTAL; k = k + 1)
        mem_q[k] <= 8'h00;
    end else if (wr_pend_q && wr_idx_q < BANK_BYTES && !bank_q[2]) begin
      // Byte mode writes only the addressed location
      mem_q[wr_pos] <= HWDATA[7:0];
      // Word write at an even offset also fills the odd byte
      if (wide_q && !wr_idx_q[0])
        mem_q[wr_pos + 6'h01] <= HWDATA[15:8];
    end
  end

  // Only a write to the shared word moves the bank
  always @(posedge MCLK) begin
    if (!RST_N) begin
      bank_q <= `EPB_BANK_RST;
      wide_q <= `EPB_CFG_WIDE_RST;
    end else if (wr_pend_q) begin
      if (wr_idx_q == IDX_BSR)
        bank_q <= HWDATA[2:0];
      if (wr_idx_q == IDX_CFG)
        wide_q <= HWDATA[0];
    end
  end

  // ==========================================================
  // Receive packet writer
  // ==========================================================
  reg [1:0] state_q;
  reg [11:0] n_q;
  reg [7:0] lo_q;
  reg [31:0] crc_q;
  reg bcast_q;
  reg mcast_q;
  reg align_q;
  reg crcerr_q;

  wire accept;
  wire [11:0] stored;
  wire odd_stored;
  wire [10:0] even_stored;
  wire [5:0] hash;
  wire [7:0] mt_byte;
  wire [15:0] status_word;
  wire [7:0] rx_ctrl;

  assign accept = RX_VALID & RX_READY;
  // Bytes past the data area limit are counted but not stored
  assign stored = (n_q > MAX_DATA) ? MAX_DATA : n_q;
  assign odd_stored = stored[0];
  assign even_stored = {stored[10:1], 1'b0};
  assign hash = crc_q[`EPB_HASH_MSB:`EPB_HASH_LSB];
  assign mt_byte = mem_q[MT_BASE + {3'h0, hash[5:3]}];
  assign rx_ctrl = `EPB_RX_CTRL_FIXED |
    ({7'h00, odd_stored} << `EPB_CTRL_ODD_BIT);

  // Length flags use every byte seen, stored or not
  assign status_word[`EPB_ST_ALIGN] = align_q;
  assign status_word[`EPB_ST_BCAST] = bcast_q;
  assign status_word[`EPB_ST_CRCERR] = crcerr_q;
  assign status_word[`EPB_ST_ODD] = odd_stored;
  assign status_word[`EPB_ST_LONG] = (n_q > MAX_CABLE);
  assign status_word[`EPB_ST_SHORT] = (n_q < MIN_CABLE);
  assign status_word[9:7] = 3'h0;
  assign status_word[6:`EPB_ST_HASH_LSB] = hash;
  assign status_word[`EPB_ST_MCAST] = mcast_q;

  always @(posedge MCLK) begin
    if (!RST_N) begin
      state_q <= S_RUN;
      n_q <= 12'h000;
      lo_q <= 8'h00;
      crc_q <= `EPB_CRC_INIT;
      bcast_q <= 1'b1;
      mcast_q <= 1'b0;
      align_q <= 1'b0;
      crcerr_q <= 1'b0;
      RX_READY <= 1'b1;
      PKT_WE <= 1'b0;
      PKT_ADDR <= 11'h000;
      PKT_WDATA <= 16'h0000;
      RX_DONE <= 1'b0;
      RX_HASH_HIT <= 1'b0;
    end else begin
      PKT_WE <= 1'b0;
      RX_DONE <= 1'b0;
      case (state_q)
        S_RUN: begin
          if (accept) begin
            // Saturate so a runaway frame still reads as too long
            if (n_q != 12'hfff)
              n_q <= n_q + 12'h001;
            if (n_q < DA_LEN) begin
              crc_q <= crc_byte(crc_q, RX_DATA);
              bcast_q <= bcast_q & (RX_DATA == 8'hff);
            end
            if (n_q == 12'h000)
              mcast_q <= RX_DATA[0];
            // Length/type and payload are stored with no inspection
            if (n_q < MAX_DATA) begin
              if (!n_q[0]) begin
                lo_q <= RX_DATA;
              end else begin
                PKT_WE <= 1'b1;
                PKT_ADDR <= `EPB_DATA_OFS +
                  {n_q[10:1], 1'b0};
                PKT_WDATA <= {RX_DATA, lo_q};
              end
            end
            if (RX_LAST) begin
              align_q <= RX_ALIGN_ERR;
              crcerr_q <= RX_CRC_ERR;
              RX_READY <= 1'b0;
              state_q <= S_FINAL;
            end
          end
        end
        S_FINAL: begin
          // Control byte high, odd data byte low
          PKT_WE <= 1'b1;
          PKT_ADDR <= `EPB_DATA_OFS + even_stored;
          PKT_WDATA <= {rx_ctrl, odd_stored ? lo_q : 8'h00};
          state_q <= S_COUNT;
        end
        S_COUNT: begin
          // Count spans status, count, data and final word
          PKT_WE <= 1'b1;
          PKT_ADDR <= `EPB_CNT_OFS;
          PKT_WDATA <= {5'h00, even_stored + OVERHEAD};
          state_q <= S_STATUS;
        end
        S_STATUS: begin
          // Status exists only in the packet; no register copy
          PKT_WE <= 1'b1;
          PKT_ADDR <= `EPB_STAT_OFS;
          PKT_WDATA <= status_word;
          RX_DONE <= 1'b1;
          RX_HASH_HIT <= mcast_q & mt_byte[hash[2:0]];
          n_q <= 12'h000;
          crc_q <= `EPB_CRC_INIT;
          bcast_q <= 1'b1;
          mcast_q <= 1'b0;
          // Next frame may start in the same cycle as the status write
          RX_READY <= 1'b1;
          state_q <= S_RUN;
        end
        default: begin
          state_q <= S_RUN;
          RX_READY <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Transmit descriptor interpretation
  // ==========================================================
  epb_tx_frame u_tx (
    .clk(MCLK),
    .rst_n(RST_N),
    .desc_valid(TX_DESC_VALID),
    .byte_count(TX_BYTE_COUNT),
    .control(TX_CONTROL),
    .crc_suppress(mem_q[`EPB_TCR_HI_IDX][`EPB_CRC_SUPPRESS_OPTION_BIT]),
    .send_valid_q(TX_SEND_VALID),
    .send_len_q(TX_SEND_LEN),
    .append_crc_q(TX_APPEND_CRC)
  );

endmodule // epb_top

//--- bench/epb_top_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker
// ==========================================================
module epb_chk (
  input wire MCLK,
  input wire RST_N,
  input wire HREADYOUT,
  input wire HRESP,
  input wire RX_VALID,
  input wire RX_LAST,
  input wire RX_READY,
  input wire PKT_WE,
  input wire [10:0] PKT_ADDR,
  input wire [15:0] PKT_WDATA,
  input wire RX_DONE,
  input wire TX_DESC_VALID,
  input wire [7:0] TX_CONTROL,
  input wire TX_SEND_VALID,
  input wire [10:0] TX_SEND_LEN,
  input wire TX_APPEND_CRC
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence tail_words;
    (!RX_READY && PKT_WE) [*2];
  endsequence
  sequence status_word;
    RX_READY && PKT_WE && RX_DONE && PKT_ADDR == 11'h000;
  endsequence
  bus_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
  rx_tail_a: assert property (
    RX_VALID && RX_READY && RX_LAST |=> !RX_READY ##1 tail_words
      ##1 status_word ##1 RX_READY)
    else $error("receive tail out of order");
  rx_even_count_a: assert property (
    PKT_WE && PKT_ADDR == 11'h002 |-> !PKT_WDATA[0] && PKT_WDATA <= 16'h0600)
    else $error("bad receive count word");
  rx_ctrl_byte_a: assert property (
    RX_DONE |-> ($past(PKT_WDATA, 2) & 16'hdf00) == 16'h4000)
    else $error("bad receive control byte");
  rx_odd_flag_a: assert property (
    RX_DONE |-> (($past(PKT_WDATA, 2) >> 1) & 16'h1000) == (PKT_WDATA & 16'h1000))
    else $error("odd flag disagrees with control byte");
  rx_word_count_a: assert property (
    RX_DONE |-> $past(PKT_WDATA, 1) == {5'h00, $past(PKT_ADDR, 2)} + 16'h0002)
    else $error("count does not match final word place");
  data_start_a: assert property (
    PKT_WE && RX_READY && !RX_DONE |-> PKT_ADDR >= 11'h004 && !PKT_ADDR[0])
    else $error("data word outside data area");
  tx_odd_len_a: assert property (
    TX_DESC_VALID |=> TX_SEND_VALID &&
      {2'b00, TX_SEND_LEN[0], 5'h00} == ($past(TX_CONTROL) & 8'h20))
    else $error("send length parity wrong");
  tx_max_len_a: assert property (
    TX_SEND_VALID |-> TX_SEND_LEN <= 11'd1531)
    else $error("send length too large");
  tx_crc_flag_a: assert property (
    TX_DESC_VALID && TX_CONTROL[4] |=> TX_APPEND_CRC)
    else $error("crc not appended");
endmodule // epb_chk

bind epb_top epb_chk u_chk (.MCLK(MCLK), .RST_N(RST_N),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_VALID(RX_VALID),
  .RX_LAST(RX_LAST), .RX_READY(RX_READY), .PKT_WE(PKT_WE),
  .PKT_ADDR(PKT_ADDR), .PKT_WDATA(PKT_WDATA), .RX_DONE(RX_DONE),
  .TX_DESC_VALID(TX_DESC_VALID), .TX_CONTROL(TX_CONTROL),
  .TX_SEND_VALID(TX_SEND_VALID), .TX_SEND_LEN(TX_SEND_LEN),
  .TX_APPEND_CRC(TX_APPEND_CRC));

//--- bench/epb_rx_source.sv
`timescale 1ns/1ps
// ==========================================================
// Receive byte source
// ==========================================================
module epb_rx_source (
  input wire clk,
  input wire rx_ready,
  output reg rx_valid,
  output reg [7:0] rx_data,
  output reg rx_last,
  output reg rx_align_err,
  output reg rx_crc_err
);
  reg [7:0] frame_q [0:2047];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    rx_align_err = 1'b0;
    rx_crc_err = 1'b0;
  end
  // Destination address leaves first, frame bytes in order
  task send(input integer n, input reg ae, input reg ce, input reg slow);
    integer i;
    begin
      @(posedge clk);
      for (i = 0; i < n; i = i + 1) begin
        if (slow && i % 3 == 1) begin
          // Idle line flips so a stale byte cannot be mistaken for data
          rx_valid <= 1'b0;
          rx_data <= ~rx_data;
          @(posedge clk);
        end
        rx_valid <= 1'b1;
        rx_data <= frame_q[i];
        rx_last <= (i == n - 1);
        rx_align_err <= ae && (i == n - 1);
        rx_crc_err <= ce && (i == n - 1);
        do @(posedge clk); while (rx_ready !== 1'b1);
      end
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~frame_q[n - 1];
      rx_align_err <= 1'b0;
      rx_crc_err <= 1'b0;
    end
  endtask
endmodule // epb_rx_source

//--- bench/epb_top_test.sv
`timescale 1ns/1ps
`include "epb_consts.vh"
module epb_top_test;
  reg MCLK = 1'b0;
  reg RST_N = 1'b0;
  reg HSEL = 1'b0;
  reg [31:0] HADDR = 32'h0;
  reg [1:0] HTRANS = 2'b00;
  reg HWRITE = 1'b0;
  reg [31:0] HWDATA = 32'h0;
  reg TX_DESC_VALID = 1'b0;
  reg [15:0] TX_BYTE_COUNT = 16'h0;
  reg [7:0] TX_CONTROL = 8'h00;
  wire [31:0] HRDATA;
  wire HREADYOUT, HRESP, RX_VALID, RX_LAST, RX_ALIGN_ERR, RX_CRC_ERR;
  wire RX_READY, PKT_WE, RX_DONE, RX_HASH_HIT;
  wire TX_SEND_VALID, TX_APPEND_CRC;
  wire [7:0] RX_DATA;
  wire [10:0] PKT_ADDR, TX_SEND_LEN;
  wire [15:0] PKT_WDATA;
  integer failures = 0, checks_done = 0, seed = 58, i, j, n, m;
  reg [15:0] mem [0:1023];
  reg [7:0] mt [0:7];
  reg [31:0] rd;
  reg [15:0] cnt;
  reg [7:0] ctl;
  reg [5:0] h;
  reg sup, hit;
  always #25 MCLK = ~MCLK;
  epb_top uut (.MCLK(MCLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HREADY(HREADYOUT),
    .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_LAST(RX_LAST),
    .RX_ALIGN_ERR(RX_ALIGN_ERR), .RX_CRC_ERR(RX_CRC_ERR),
    .RX_READY(RX_READY), .PKT_WE(PKT_WE), .PKT_ADDR(PKT_ADDR),
    .PKT_WDATA(PKT_WDATA), .RX_DONE(RX_DONE), .RX_HASH_HIT(RX_HASH_HIT),
    .TX_DESC_VALID(TX_DESC_VALID), .TX_BYTE_COUNT(TX_BYTE_COUNT),
    .TX_CONTROL(TX_CONTROL), .TX_SEND_VALID(TX_SEND_VALID),
    .TX_SEND_LEN(TX_SEND_LEN), .TX_APPEND_CRC(TX_APPEND_CRC));
  epb_rx_source src (.clk(MCLK), .rx_ready(RX_READY), .rx_valid(RX_VALID),
    .rx_data(RX_DATA), .rx_last(RX_LAST), .rx_align_err(RX_ALIGN_ERR),
    .rx_crc_err(RX_CRC_ERR));
  always @(posedge MCLK) if (PKT_WE === 1'b1) mem[PKT_ADDR[10:1]] <= PKT_WDATA;
  // ==========================================================
  // Helpers
  // ==========================================================
  task chk(input [8*8:1] name, input [31:0] exp, input [31:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task ahb(input reg wr, input [4:0] idx, input [31:0] wd);
    begin
      @(posedge MCLK);
      HSEL <= 1'b1;
      HADDR <= {25'h0, idx, 2'b00};
      HTRANS <= `EPB_HTRANS_NONSEQ;
      HWRITE <= wr;
      do @(posedge MCLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'b00;
      HSEL <= 1'b0;
      HWDATA <= wd;
      do @(posedge MCLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
    end
  endtask
  function [10:0] exp_len(input [15:0] c, input [7:0] t);
    reg [15:0] e;
    begin
      e = c & 16'hfffe;
      if (e > 16'd1536) e = 16'd1536;
      e = (e > 16'd6) ? e - 16'd6 : 16'd0;
      exp_len = e[10:0] + {10'h0, t[5]};
    end
  endfunction
  function [5:0] hash6(input integer unused);
    reg [31:0] c;
    integer k, b;
    begin
      c = `EPB_CRC_INIT;
      for (k = 0; k < 6; k = k + 1) begin
        c = c ^ {24'h0, src.frame_q[k]};
        for (b = 0; b < 8; b = b + 1)
          c = c[0] ? (c >> 1) ^ `EPB_CRC_POLY : c >> 1;
      end
      hash6 = c[31:26];
    end
  endfunction
  task rx_frame(input reg ae, input reg ce, input reg slow);
    reg bc;
    begin
      bc = {src.frame_q[0], src.frame_q[1], src.frame_q[2], src.frame_q[3],
        src.frame_q[4], src.frame_q[5]} == 48'hffffffffffff;
      src.send(m, ae, ce, slow);
      n = 0;
      do begin
        @(posedge MCLK);
        #1;
        n = n + 1;
      end while (RX_DONE !== 1'b1 && n < 10);
      chk("done", 1, RX_DONE);
      @(posedge MCLK);
      #1;
      hit = RX_HASH_HIT;
      chk("status", {ae, bc, ce, m[0], m > 1518, m < 64, 3'b000, hash6(0),
        src.frame_q[0][0]}, mem[0]);
      chk("count", m - m % 2 + 6, mem[1]);
      chk("ctrl", {2'b01, m[0], 5'h0}, mem[(4 + m - m % 2) / 2][15:8]);
      for (j = 0; j < m; j = j + 1)
        chk("data", src.frame_q[j], j[0] ? mem[2 + j / 2][15:8] :
          mem[2 + j / 2][7:0]);
      chk("hashhit", src.frame_q[0][0] & mt[h[5:3]][h[2:0]], hit);
    end
  endtask
  task tally_and_finish;
    begin
      if (failures == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #4000000;
    failures = failures + 1;
    tally_and_finish;
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b1;
    ahb(0, 14, 0);
    chk("bank", 32'h3300, rd);
    ahb(0, 16, 0);
    chk("wide", 1, rd);
    ahb(1, 20, 32'hffff);
    ahb(0, 20, 0);
    chk("unmapped", 0, rd);
    ahb(1, 14, 3);
    ahb(0, 15, 0);
    chk("bankhi", 32'h33, rd);
    for (i = 0; i < 8; i = i + 2) begin
      rd = $random(seed);
      mt[i] = rd[7:0];
      mt[i + 1] = rd[15:8];
      ahb(1, i, rd);
      ahb(0, i, 0);
      chk("mt", {mt[i + 1], mt[i]}, rd);
      ahb(0, i + 1, 0);
      chk("mt_hi", mt[i + 1], rd);
    end
    for (i = 4; i < 8; i = i + 1) begin
      ahb(1, 14, i);
      ahb(1, 0, 32'h5a5a);
      ahb(0, 1, 0);
      chk("nobank", 8'h33, rd);
      ahb(0, 14, 0);
      chk("bsel", 32'h3300 | i, rd);
    end
    ahb(1, 14, 3);
    ahb(0, 0, 0);
    chk("mtkeep", {mt[1], mt[0]}, rd);
    for (i = 0; i < 5; i = i + 1) begin
      m = i == 0 ? 60 : i == 1 ? 1519 : i == 2 ? 65 + {$random(seed)} % 35 :
        i == 3 ? 64 : 1518;
      for (j = 0; j < m; j = j + 1) src.frame_q[j] = $random(seed);
      for (j = 0; j < 6 && i == 0; j = j + 1) src.frame_q[j] = 8'hff;
      src.frame_q[0][0] = (i == 0 || i == 2);
      h = hash6(0);
      if (i == 2) begin
        mt[h[5:3]][h[2:0]] = 1'b1;
        ahb(1, {2'b00, h[5:4], 1'b0}, {mt[h[5:3] | 1], mt[h[5:3] & 6]});
      end
      rx_frame(i == 2, i == 1, i[0]);
    end
    ahb(1, 14, 0);
    for (n = 0; n < 2; n = n + 1) begin
      sup = n;
      ahb(1, 1, sup);
      for (i = 0; i < 12; i = i + 1) begin
        cnt = i == 0 ? 0 : i == 1 ? 7 : i == 2 ? 1536 : i == 3 ? 1537 :
          i == 4 ? 16'hffff : $random(seed);
        ctl = $random(seed) & 8'hf0;
        TX_DESC_VALID <= 1'b1;
        TX_BYTE_COUNT <= cnt;
        TX_CONTROL <= ctl;
        @(posedge MCLK);
        TX_DESC_VALID <= 1'b0;
        @(posedge MCLK);
        chk("txvalid", 1, TX_SEND_VALID);
        chk("txlen", exp_len(cnt, ctl), TX_SEND_LEN);
        chk("txcrc", !sup | ctl[4], TX_APPEND_CRC);
      end
    end
    tally_and_finish;
  end
endmodule // epb_top_test
